// ---- shared/sensor_cfg_regs.svh ----
`ifndef SENSOR_CFG_REGS_SVH
`define SENSOR_CFG_REGS_SVH

// Register offsets (byte addresses on the primary interface)
`define OFF_FEATURE_CONFIG_PORT   8'h5e
`define OFF_INTERNAL_FAULT_FLAGS  8'h5f
`define OFF_NONVOLATILE_PROGRAM   8'h6a
`define OFF_SERIAL_IF_SETTINGS    8'h6b
`define OFF_SELF_TEST_CONTROL     8'h6d
`define OFF_PERSISTENT_CONFIG     8'h70
`define OFF_X_AXIS_OFFSET         8'h71
`define OFF_COMMAND               8'h7e
`define OFF_IRQ_STATUS            8'h60
`define OFF_IRQ_MASK              8'h61

// Field positions
`define BIT_FAULT_TIMEOUT         1
`define BIT_FAULT_FATAL           2
`define BIT_PROG_ENABLE           1
`define BIT_THREE_WIRE_SELECT     0
`define BIT_AUX_MODE              4
`define BIT_ST_ENABLE             0
`define BIT_ST_SIGN               2
`define BIT_ST_AMP                3
`define BIT_PC_SPI_ENABLE         0
`define BIT_PC_WDT_SELECT         1
`define BIT_PC_WDT_ENABLE         2
`define BIT_PC_OFFSET_ENABLE      3

// Writable masks
`define MASK_PROG                 8'h02
`define MASK_SERIAL_IF            8'h11
`define MASK_SELF_TEST            8'h0d
`define MASK_PERSISTENT           8'h0f
`define MASK_IRQ                  8'h07

// Reset values
`define RST_ZERO                  8'h00

// Commands
`define CMD_NVM_PROGRAM           8'ha0

// Watchdog times in microseconds
`define WDT_SHORT_US              1250
`define WDT_LONG_US               40000
`define CLK_MHZ                   20

// Programming time in clock cycles, a plain default
`define NVM_PROG_CYCLES           16

`endif

// ---- shared/sensor_cfg_pkg.sv ----
`default_nettype none

package sensor_cfg_pkg;
   typedef struct packed {
      logic       we;
      logic       re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic spi_select;
      logic three_wire;
      logic aux_mag;
      logic self_test_en;
      logic self_test_pos;
      logic self_test_high;
      logic offset_add_en;
   } cfg_out_type;

   typedef enum logic [1:0] {
      NVM_IDLE = 2'b00,
      NVM_BUSY = 2'b01,
      NVM_DONE = 2'b10
   } nvm_state_type;
endpackage

`default_nettype wire

// ---- core/sensor_config_register_group.sv ----
// Overview of operation
// - Feature port byte, read/write, resets zero
// - Timeout fault sets bit one, halts processing
// - Fatal fault sets bit two, halts processing
// - Programming allowed only while enable bit set
// - Bit zero selects three-wire SPI
// - Aux mode off or magnetometer
// - Self-test excitation enable bit
// - Self-test sign: negative zero, positive one
// - Self-test amplitude: low zero, high one
// - Autoconfig: one disables I2C, enables SPI
// - Watchdog timeout 1.25 ms or 40 ms
// - SDA watchdog only in I2C mode
// - Offset added to acceleration when enabled
// - X offset byte, NVM backed, resets zero
// - Persistent low nibble NVM backed, resets zero
// - Command 0xa0 copies backed registers to NVM
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_regs.svh"

module sensor_config_register_group
   import sensor_cfg_pkg::*;
#(
   parameter int WDT_SHORT_CYC = (`WDT_SHORT_US * `CLK_MHZ),
   parameter int WDT_LONG_CYC  = (`WDT_LONG_US * `CLK_MHZ),
   parameter int NVM_PROG_CYC  = `NVM_PROG_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire bus_req_type bus_req,
   output logic [7:0]       rdata,
   input  wire logic        fault_timeout_raw,
   input  wire logic        fault_fatal_raw,
   input  wire logic        i2c_mode_raw,
   input  wire logic        sda_raw,
   input  wire logic [15:0] accel_x_in,
   output logic [15:0]      accel_x_out,
   output cfg_out_type      cfg_out,
   output logic             processing_halt,
   output logic             wdt_timeout,
   output logic             nvm_write_pulse,
   output logic [15:0]      nvm_image,
   output logic             irq
);

   // A one-cycle watchdog limit would pulse every cycle; the programming count is 16 bits
   if (WDT_SHORT_CYC < 2 || WDT_LONG_CYC <= WDT_SHORT_CYC
       || NVM_PROG_CYC < 1 || NVM_PROG_CYC > 65536) begin : g_bad_timing
      $error("timing parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for pin-side inputs
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {fault_timeout_raw, fault_fatal_raw, i2c_mode_raw, sda_raw};
         sync2_r <= sync1_r;
      end
   end
   logic f_timeout, f_fatal, i2c_mode, sda;
   assign {f_timeout, f_fatal, i2c_mode, sda} = sync2_r;

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] feature_config_port_r;
   logic [7:0] internal_fault_flags_r;
   logic [7:0] nonvolatile_program_control_r;
   logic [7:0] serial_interface_settings_r;
   logic [7:0] self_test_control_r;
   logic [7:0] persistent_config_r;
   logic [7:0] x_axis_offset_r;
   logic [7:0] irq_status_r;
   logic [7:0] irq_mask_r;
   logic       wr;
   logic [7:0] wa;
   logic [7:0] wd;
   assign wr = bus_req.we;
   assign wa = bus_req.addr;
   assign wd = bus_req.wdata;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         feature_config_port_r <= `RST_ZERO;
      end else if (wr && wa == `OFF_FEATURE_CONFIG_PORT) begin
         feature_config_port_r <= wd;
      end
   end

   // Fault flags are sticky until reset: processing stays halted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         internal_fault_flags_r <= `RST_ZERO;
      end else begin
         if (f_timeout)
            internal_fault_flags_r[`BIT_FAULT_TIMEOUT] <= 1'b1;
         if (f_fatal)
            internal_fault_flags_r[`BIT_FAULT_FATAL] <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         processing_halt <= 1'b0;
      end else begin
         processing_halt <= |internal_fault_flags_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nonvolatile_program_control_r <= `RST_ZERO;
         serial_interface_settings_r   <= `RST_ZERO;
         self_test_control_r           <= `RST_ZERO;
         persistent_config_r           <= `RST_ZERO;
         x_axis_offset_r               <= `RST_ZERO;
      end else if (wr) begin
         case (wa)
            `OFF_NONVOLATILE_PROGRAM: nonvolatile_program_control_r <= wd & `MASK_PROG;
            `OFF_SERIAL_IF_SETTINGS:  serial_interface_settings_r <= wd & `MASK_SERIAL_IF;
            `OFF_SELF_TEST_CONTROL:   self_test_control_r <= wd & `MASK_SELF_TEST;
            `OFF_PERSISTENT_CONFIG:   persistent_config_r <= wd & `MASK_PERSISTENT;
            `OFF_X_AXIS_OFFSET:       x_axis_offset_r <= wd;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // NVM programming sequencer
   nvm_state_type nvm_state_r;
   logic [15:0]   nvm_cnt_r;
   logic          cmd_prog;
   logic          prog_ok;
   assign cmd_prog = wr && wa == `OFF_COMMAND && wd == `CMD_NVM_PROGRAM;
   assign prog_ok  = nonvolatile_program_control_r[`BIT_PROG_ENABLE];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm_state_r     <= NVM_IDLE;
         nvm_cnt_r       <= 16'h0000;
         nvm_write_pulse <= 1'b0;
         nvm_image       <= 16'h0000;
      end else begin
         nvm_write_pulse <= 1'b0;
         case (nvm_state_r)
            NVM_IDLE: begin
               // Controller stays read-only without the enable
               if (cmd_prog && prog_ok) begin
                  nvm_state_r <= NVM_BUSY;
                  nvm_cnt_r   <= 16'(NVM_PROG_CYC - 1);
                  nvm_image   <= {x_axis_offset_r, persistent_config_r};
               end
            end
            NVM_BUSY: begin
               if (nvm_cnt_r == 16'h0000) begin
                  nvm_state_r     <= NVM_DONE;
                  nvm_write_pulse <= 1'b1;
               end else begin
                  nvm_cnt_r <= nvm_cnt_r - 16'h0001;
               end
            end
            NVM_DONE: nvm_state_r <= NVM_IDLE;
            default:  nvm_state_r <= NVM_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // SDA stuck-low watchdog
   logic [31:0] wdt_cnt_r;
   logic [31:0] wdt_limit;
   logic        wdt_active;
   assign wdt_limit = persistent_config_r[`BIT_PC_WDT_SELECT] ? 32'(WDT_LONG_CYC)
                                                             : 32'(WDT_SHORT_CYC);
   assign wdt_active = persistent_config_r[`BIT_PC_WDT_ENABLE] && i2c_mode
                       && !persistent_config_r[`BIT_PC_SPI_ENABLE];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_cnt_r   <= 32'h0;
         wdt_timeout <= 1'b0;
      end else begin
         wdt_timeout <= 1'b0;
         if (!wdt_active || sda) begin
            wdt_cnt_r <= 32'h0;
         end else if (wdt_cnt_r >= wdt_limit - 32'h1) begin
            wdt_cnt_r   <= 32'h0;
            wdt_timeout <= 1'b1;
         end else begin
            wdt_cnt_r <= wdt_cnt_r + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration outputs and offset path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_out <= '0;
      end else begin
         cfg_out.spi_select     <= persistent_config_r[`BIT_PC_SPI_ENABLE];
         cfg_out.three_wire     <= serial_interface_settings_r[`BIT_THREE_WIRE_SELECT];
         cfg_out.aux_mag        <= serial_interface_settings_r[`BIT_AUX_MODE];
         cfg_out.self_test_en   <= self_test_control_r[`BIT_ST_ENABLE];
         cfg_out.self_test_pos  <= self_test_control_r[`BIT_ST_SIGN];
         cfg_out.self_test_high <= self_test_control_r[`BIT_ST_AMP];
         cfg_out.offset_add_en  <= persistent_config_r[`BIT_PC_OFFSET_ENABLE];
      end
   end

   // Offset is signed; halted processing freezes the output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accel_x_out <= 16'h0000;
      end else if (!processing_halt) begin
         if (persistent_config_r[`BIT_PC_OFFSET_ENABLE])
            accel_x_out <= accel_x_in + {{8{x_axis_offset_r[7]}}, x_axis_offset_r};
         else
            accel_x_out <= accel_x_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: bit0 watchdog, bit1 nvm done, bit2 fault
   logic [7:0] irq_evt;
   logic [7:0] irq_clr;
   assign irq_evt = {5'h00, |internal_fault_flags_r, nvm_write_pulse, wdt_timeout};
   assign irq_clr = (wr && wa == `OFF_IRQ_STATUS) ? (wd & `MASK_IRQ) : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_r <= `RST_ZERO;
      end else begin
         // Set wins over a same-cycle clear
         irq_status_r <= ((irq_status_r & ~irq_clr) | irq_evt) & `MASK_IRQ;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= `RST_ZERO;
      end else if (wr && wa == `OFF_IRQ_MASK) begin
         irq_mask_r <= wd & `MASK_IRQ;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (bus_req.re) begin
         case (bus_req.addr)
            `OFF_FEATURE_CONFIG_PORT:  rdata <= feature_config_port_r;
            `OFF_INTERNAL_FAULT_FLAGS: rdata <= internal_fault_flags_r;
            `OFF_NONVOLATILE_PROGRAM:  rdata <= nonvolatile_program_control_r;
            `OFF_SERIAL_IF_SETTINGS:   rdata <= serial_interface_settings_r;
            `OFF_SELF_TEST_CONTROL:    rdata <= self_test_control_r;
            `OFF_PERSISTENT_CONFIG:    rdata <= persistent_config_r;
            `OFF_X_AXIS_OFFSET:        rdata <= x_axis_offset_r;
            `OFF_IRQ_STATUS:           rdata <= irq_status_r;
            `OFF_IRQ_MASK:             rdata <= irq_mask_r;
            default:                   rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_prog_cmd;
      cmd_prog && prog_ok && nvm_state_r == NVM_IDLE;
   endsequence

   a_nvm_prog_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      s_prog_cmd |-> ##1 (nvm_state_r == NVM_BUSY) ##[1:300] nvm_write_pulse)
      else $error("nvm program did not complete");

   a_nvm_locked: assert property (@(posedge clk) disable iff (!rst_n)
      (nvm_state_r == NVM_IDLE && !(cmd_prog && prog_ok)) |=> nvm_state_r == NVM_IDLE)
      else $error("nvm left idle without enable");

   a_fault_timeout: assert property (@(posedge clk) disable iff (!rst_n)
      f_timeout |=> internal_fault_flags_r[`BIT_FAULT_TIMEOUT] ##1 processing_halt)
      else $error("timeout fault not flagged");

   a_fault_fatal: assert property (@(posedge clk) disable iff (!rst_n)
      f_fatal |=> internal_fault_flags_r[`BIT_FAULT_FATAL] ##1 processing_halt)
      else $error("fatal fault not flagged");

   a_feature_write: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && wa == `OFF_FEATURE_CONFIG_PORT) |=> feature_config_port_r == $past(wd))
      else $error("feature port write lost");

   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (persistent_config_r[7:4] == 4'h0) && (self_test_control_r[1] == 1'b0))
      else $error("reserved bits set");

   a_wdt_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !wdt_active |=> !wdt_timeout)
      else $error("watchdog fired outside i2c");

   a_three_wire: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 cfg_out.three_wire == $past(serial_interface_settings_r[0]))
      else $error("three wire output wrong");

   a_offset_add: assert property (@(posedge clk) disable iff (!rst_n)
      (persistent_config_r[3] && !processing_halt) |=>
      accel_x_out == $past(accel_x_in) + {{8{$past(x_axis_offset_r[7])}}, $past(x_axis_offset_r)})
      else $error("offset not applied");

   a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
      |(irq_status_r & irq_mask_r) |=> irq)
      else $error("irq not raised");

   // Flags have no clear path, so the halt only drops on reset
   a_halt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      processing_halt |=> processing_halt)
      else $error("halt released without reset");

   a_halt_freeze: assert property (@(posedge clk) disable iff (!rst_n)
      processing_halt |=> $stable(accel_x_out))
      else $error("output moved while halted");

   a_offset_bypass: assert property (@(posedge clk) disable iff (!rst_n)
      (!persistent_config_r[`BIT_PC_OFFSET_ENABLE] && !processing_halt)
      |=> accel_x_out == $past(accel_x_in))
      else $error("offset added while disabled");

   a_x_offset_write: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && wa == `OFF_X_AXIS_OFFSET) |=> x_axis_offset_r == $past(wd))
      else $error("x offset write lost");

   a_reserved_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
      ((nonvolatile_program_control_r & ~`MASK_PROG) == 8'h00)
      && ((serial_interface_settings_r & ~`MASK_SERIAL_IF) == 8'h00))
      else $error("reserved control bits set");

   a_command_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_req.re && bus_req.addr == `OFF_COMMAND) |=> rdata == 8'h00)
      else $error("command register read nonzero");

   a_spi_stops_wdt: assert property (@(posedge clk) disable iff (!rst_n)
      persistent_config_r[`BIT_PC_SPI_ENABLE] |=> wdt_cnt_r == 32'h0)
      else $error("watchdog counting with spi selected");

   a_wdt_single_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      wdt_timeout |=> !wdt_timeout)
      else $error("watchdog pulse too long");

   // Image must not change while the write is under way
   a_image_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (nvm_state_r != NVM_IDLE) |=> $stable(nvm_image))
      else $error("nvm image changed while busy");

   a_status_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      nvm_write_pulse |=> irq_status_r[1])
      else $error("nvm done status lost");

endmodule

`default_nettype wire

// ---- verification/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
   import sensor_cfg_pkg::*;
(
   input  wire logic       clk,
   output var bus_req_type bus_req,
   input  wire logic [7:0] rdata
);

   initial bus_req = '0;

   ////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse, so a stale address is never reused
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      bus_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~v};
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'hff};
      #1 v = rdata;
   endtask

endmodule

`default_nettype wire

// ---- verification/sensor_config_register_group_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module sensor_config_register_group_test
   import sensor_cfg_pkg::*;
;

   logic        clk;
   logic        rst_n;
   logic        tmo;
   logic        fatal;
   logic        i2c;
   logic        sda;
   logic [15:0] accel_in;
   bus_req_type bus_req;
   logic [7:0]  rdata;
   logic [15:0] accel_out;
   logic [15:0] nvm_image;
   cfg_out_type cfg_out;
   logic        halt;
   logic        wdt;
   logic        nvm_pulse;
   logic        irq;
   int          errors;
   int          n_tests;
   int          n;
   logic [7:0]  addrs [7] = '{8'h5e, 8'h5f, 8'h6a, 8'h6b, 8'h6d, 8'h70, 8'h71};
   logic [7:0]  masks [7] = '{8'hff, 8'h00, 8'h02, 8'h11, 8'h0d, 8'h0f, 8'hff};

   // Short watchdog limits keep the run brief
   sensor_config_register_group #(
      .WDT_SHORT_CYC (20),
      .WDT_LONG_CYC  (40)
   ) i_sensor_config_register_group (
      .clk               (clk),
      .rst_n             (rst_n),
      .bus_req           (bus_req),
      .rdata             (rdata),
      .fault_timeout_raw (tmo),
      .fault_fatal_raw   (fatal),
      .i2c_mode_raw      (i2c),
      .sda_raw           (sda),
      .accel_x_in        (accel_in),
      .accel_x_out       (accel_out),
      .cfg_out           (cfg_out),
      .processing_halt   (halt),
      .wdt_timeout       (wdt),
      .nvm_write_pulse   (nvm_pulse),
      .nvm_image         (nvm_image),
      .irq               (irq)
   );

   host_bus_model i_host_bus_model (
      .clk     (clk),
      .bus_req (bus_req),
      .rdata   (rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_host_bus_model.wr(a, v);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_host_bus_model.rd(a, v);
      chk({8'h00, v}, {8'h00, exp});
   endtask

   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // First pulse may come mid-count, so only the following gap is measured
   task automatic pulse_gap(output int g);
      int c;
      c = 0;
      while (wdt !== 1'b1 && c < 200) begin
         @(posedge clk);
         #1 c++;
      end
      g = 0;
      do begin
         @(posedge clk);
         #1 g++;
      end while (wdt !== 1'b1 && g < 200);
   endtask

   task automatic stop_test();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      #(6000 * 50);
      errors++;
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      tmo = 1'b0;
      fatal = 1'b0;
      i2c = 1'b0;
      sda = 1'b1;
      accel_in = 16'h0100;
      errors = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
      rd_chk(8'h7e, 8'h00);
      rd_chk(8'h40, 8'h00);
      foreach (addrs[i]) begin
         wr(addrs[i], 8'hff);
         rd_chk(addrs[i], masks[i]);
      end
      wr(8'h5e, 8'ha5);
      rd_chk(8'h5e, 8'ha5);
      // Each config bit is seen both set and clear
      wr(8'h6b, 8'h11);
      wr(8'h6d, 8'h0d);
      wr(8'h70, 8'h09);
      cycles(2);
      chk({9'h000, cfg_out}, 16'h007f);
      wr(8'h6b, 8'h10);
      wr(8'h6d, 8'h04);
      wr(8'h70, 8'h00);
      cycles(2);
      chk({9'h000, cfg_out}, 16'h0014);
      wr(8'h6b, 8'h01);
      wr(8'h6d, 8'h09);
      wr(8'h70, 8'h01);
      cycles(2);
      chk({9'h000, cfg_out}, 16'h006a);
      wr(8'h71, 8'h80);
      wr(8'h70, 8'h08);
      cycles(3);
      chk(accel_out, 16'h0080);
      wr(8'h71, 8'h05);
      cycles(3);
      chk(accel_out, 16'h0105);
      wr(8'h70, 8'h00);
      cycles(3);
      chk(accel_out, 16'h0100);
      wr(8'h71, 8'h3c);
      wr(8'h70, 8'h0a);
      wr(8'h6a, 8'h00);
      wr(8'h7e, 8'ha0);
      n = 0;
      repeat (30) begin
         @(posedge clk);
         #1 if (nvm_pulse === 1'b1) n++;
      end
      chk(16'(n), 16'h0000);
      wr(8'h6a, 8'h02);
      wr(8'h7e, 8'ha0);
      n = 0;
      while (nvm_pulse !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      chk(16'(n >= 16 && n <= 17), 16'h0001);
      chk(nvm_image, 16'h3c0a);
      cycles(2);
      rd_chk(8'h60, 8'h02);
      wr(8'h60, 8'h02);
      rd_chk(8'h60, 8'h00);
      wr(8'h70, 8'h04);
      @(posedge clk);
      i2c <= 1'b1;
      sda <= 1'b0;
      pulse_gap(n);
      chk(16'(n >= 20 && n <= 21), 16'h0001);
      wr(8'h70, 8'h06);
      pulse_gap(n);
      chk(16'(n >= 40 && n <= 41), 16'h0001);
      rd_chk(8'h60, 8'h01);
      wr(8'h61, 8'h00);
      cycles(2);
      chk({15'h0000, irq}, 16'h0000);
      wr(8'h61, 8'h01);
      cycles(2);
      chk({15'h0000, irq}, 16'h0001);
      wr(8'h70, 8'h05);
      cycles(3);
      wr(8'h60, 8'h01);
      cycles(60);
      rd_chk(8'h60, 8'h00);
      chk({15'h0000, irq}, 16'h0000);
      wr(8'h70, 8'h04);
      @(posedge clk);
      i2c <= 1'b0;
      cycles(3);
      wr(8'h60, 8'h01);
      cycles(60);
      rd_chk(8'h60, 8'h00);
      // Faults stick until reset, so they come last
      wr(8'h61, 8'h04);
      @(posedge clk);
      tmo <= 1'b1;
      cycles(5);
      rd_chk(8'h5f, 8'h02);
      chk({14'h0000, halt, irq}, 16'h0003);
      @(posedge clk);
      accel_in <= 16'h1234;
      cycles(4);
      chk(accel_out, 16'h0100);
      @(posedge clk);
      fatal <= 1'b1;
      cycles(5);
      rd_chk(8'h5f, 8'h06);
      stop_test();
   end

endmodule

`default_nettype wire
